// ---- hw/pmc_pkg.sv ----
// Shared constants, types and the switching-rate decode for the config bank.
// Assumes one 125 MHz core clock and a byte-wide register port on that clock.
package pmc_pkg;

	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_RATE    = 8'h8A;
	localparam logic [7:0] ADDR_TICK    = 8'h8B;
	localparam logic [7:0] ADDR_SCRATCH = 8'h8E;
	localparam logic [7:0] ADDR_RUN     = 8'h8F;
	localparam logic [7:0] ADDR_DLY1    = 8'h90;
	localparam logic [7:0] ADDR_DLY2    = 8'h91;
	localparam logic [7:0] ADDR_MODE    = 8'h92;
	localparam logic [7:0] ADDR_NONE_RD = 8'h00;

	// --------------------------------------------------------------
	// Reset values and field positions
	// --------------------------------------------------------------
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam int CONV_CNT      = 4;
	localparam int RATE_W        = 2;
	localparam int TICK_EXP_W    = 5;
	localparam int SCRATCH_W     = 4;
	localparam int RUN_BIT       = 0;
	localparam int MODE_SEL_BIT  = 7;
	localparam int MON_EN_BIT    = 6;
	localparam int ENDRV_BIT     = 5;
	localparam int ERR_TH_W      = 4;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int TICK_BASE_NS  = 50;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_ACC_W    = 40;

	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_2M2 = 2'b00,
		RATE_4M4 = 2'b01,
		RATE_8M8 = 2'b10
	} pmc_rate_t;

	typedef struct packed {
		logic                   loaded;
		logic                   rate_wr_en;
		logic [7:0]             rate;
		logic [7:0]             tick;
		logic [7:0]             scratch;
		logic [7:0]             run;
		logic [7:0]             dly1;
		logic [7:0]             dly2;
		logic [7:0]             mode;
		logic [7:0]             rdata;
		logic                   rvalid;
		logic                   drv_clr;
		pmc_rate_t [CONV_CNT-1:0] conv;
	} pmc_state_t;

	localparam pmc_state_t PMC_STATE_RST = '{
		loaded:     1'b0,
		rate_wr_en: 1'b0,
		rate:       RST_BYTE,
		tick:       RST_BYTE,
		scratch:    RST_BYTE,
		run:        RST_BYTE,
		dly1:       RST_BYTE,
		dly2:       RST_BYTE,
		mode:       RST_BYTE,
		rdata:      RST_BYTE,
		rvalid:     1'b0,
		drv_clr:    1'b0,
		conv:       '{CONV_CNT{RATE_2M2}}
	};

	typedef struct packed {
		logic [TICK_EXP_W-1:0] last_exp;
		logic [TICK_ACC_W-1:0] acc;
		logic                  tick;
	} pmc_tick_state_t;

	localparam pmc_tick_state_t PMC_TICK_RST = '{
		last_exp: 5'h00,
		acc:      40'h00_0000_0000,
		tick:     1'b0
	};

	// Codes 10 and 11 both mean the fastest rate
	function automatic pmc_rate_t decode_rate(input logic [1:0] code);
		case (code)
			2'b00:   return RATE_2M2;
			2'b01:   return RATE_4M4;
			default: return RATE_8M8;
		endcase
	endfunction

endpackage

// ---- hw/pmc_tick_gen.sv ----
// Sequencer delay tick generator: one pulse per 50 ns * 2^exponent.
// Assumes the exponent comes from a flop on the same clock.
`timescale 1ns/1ps

module pmc_tick_gen
	import pmc_pkg::*;
#(
	parameter int BASE_NS   = TICK_BASE_NS,
	parameter int PERIOD_NS = CLK_PERIOD_NS
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic [TICK_EXP_W-1:0] tick_exp_i,
	output logic                       tick_o
);

	localparam logic [TICK_ACC_W-1:0] BASE_W = TICK_ACC_W'(BASE_NS);
	localparam logic [TICK_ACC_W-1:0] STEP_W = TICK_ACC_W'(PERIOD_NS);

	pmc_tick_state_t s;
	pmc_tick_state_t next_s;
	logic [TICK_ACC_W-1:0] step_ns;
	logic [TICK_ACC_W-1:0] sum_ns;

	// ----------------------------------------------------------------
	// Fractional accumulator
	// ----------------------------------------------------------------
	// Period at exponent 0 or 1 is not a whole number of clocks; accumulating nanoseconds
	// keeps the long-run rate exact at the cost of one cycle of jitter.
	always_comb begin
		step_ns = BASE_W << tick_exp_i;
		sum_ns  = s.acc + STEP_W;
		next_s  = s;
		next_s.tick     = 1'b0;
		next_s.last_exp = tick_exp_i;
		if (tick_exp_i != s.last_exp) begin
			next_s.acc = '0;
		end else if (sum_ns >= step_ns) begin
			next_s.acc  = sum_ns - step_ns;
			next_s.tick = 1'b1;
		end else begin
			next_s.acc = sum_ns;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= PMC_TICK_RST;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

	// With the smallest step (50 ns) ticks are six or seven clocks apart
	AST_TICK_SPACING: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(s.tick && tick_exp_i == 5'h00 && $stable(tick_exp_i))
			|=> (!s.tick || tick_exp_i != 5'h00) [*5]
			##[1:2] (s.tick || tick_exp_i != 5'h00)
	) else $error("tick spacing wrong at smallest step");

endmodule

// ---- hw/pmc_cfg_bank.sv ----
// Misc configuration bank: converter rate selects, sequencer tick scale,
// scratch bits and host error monitor start and delay settings.
// Assumes the serial host front end presents byte accesses on core_clk_i
// and non-volatile defaults are stable when reset is released.
`timescale 1ns/1ps

// How it works
// - Rate code 00 is 2.2 MHz, 01 is 4.4 MHz, 10 and 11 8.8 MHz.
// - Rate register holds converter 4..1 selects in bits 7:6 down to 1:0.
// - A non-volatile flag makes the rate fields writable or read-only.
// - Rate, tick scale and scratch bits load from non-volatile values.
// - Sequencer tick is 50 ns times two to the bits 4:0 exponent.
// - Monitor idle while run bit 0; then clear driver enable if enabled.
// - First monitor delay is an eight-bit register.
// - Second monitor delay is an eight-bit register.
// - Delay registers accept writes only while the monitor is stopped.
// - Monitor enable, locked while running, loads from non-volatile value.
module pmc_cfg_bank
	import pmc_pkg::*;
(
	input  wire logic                  core_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic [7:0]            nvm_rate_i,
	input  wire logic                  nvm_rate_wr_en_i,
	input  wire logic [TICK_EXP_W-1:0] nvm_tick_exp_i,
	input  wire logic [SCRATCH_W-1:0]  nvm_scratch_i,
	input  wire logic                  nvm_mon_en_i,
	output logic [7:0]                 reg_rdata_o,
	output logic                       reg_rvalid_o,
	output pmc_rate_t                  conv1_rate_choice_o,
	output pmc_rate_t                  conv2_rate_choice_o,
	output pmc_rate_t                  conv3_rate_choice_o,
	output pmc_rate_t                  conv4_rate_choice_o,
	output logic [TICK_EXP_W-1:0]      sequencer_tick_exponent_o,
	output logic                       sequencer_tick_o,
	output logic [SCRATCH_W-1:0]       scratch_o,
	output logic                       monitor_run_bit_o,
	output logic                       monitor_enable_bit_o,
	output logic                       monitor_mode_o,
	output logic                       monitor_endrv_o,
	output logic [ERR_TH_W-1:0]        monitor_err_th_o,
	output logic [7:0]                 monitor_first_delay_o,
	output logic [7:0]                 monitor_second_delay_o,
	output logic                       driver_enable_clear_o
);

	pmc_state_t s;
	pmc_state_t next_s;
	logic       running;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [7:0] addr,
		input pmc_state_t st);
		if (addr == ADDR_RATE) begin
			return st.rate;
		end else if (addr == ADDR_TICK) begin
			return st.tick;
		end else if (addr == ADDR_SCRATCH) begin
			return st.scratch;
		end else if (addr == ADDR_RUN) begin
			return st.run;
		end else if (addr == ADDR_DLY1) begin
			return st.dly1;
		end else if (addr == ADDR_DLY2) begin
			return st.dly2;
		end else if (addr == ADDR_MODE) begin
			return st.mode;
		end else begin
			return ADDR_NONE_RD;
		end
	endfunction

	assign running = s.run[RUN_BIT];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s        = s;
		next_s.rvalid = 1'b0;
		if (!s.loaded) begin
			// First cycle after reset pulls the non-volatile defaults;
			// host writes in that cycle are dropped.
			next_s.loaded     = 1'b1;
			next_s.rate       = nvm_rate_i;
			next_s.rate_wr_en = nvm_rate_wr_en_i;
			next_s.tick       = {s.tick[7:TICK_EXP_W], nvm_tick_exp_i};
			next_s.scratch    = {s.scratch[7:SCRATCH_W], nvm_scratch_i};
			next_s.mode[MON_EN_BIT] = nvm_mon_en_i;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_RATE) begin
				if (s.rate_wr_en) begin
					next_s.rate = reg_wdata_i;
				end
			end else if (reg_addr_i == ADDR_TICK) begin
				next_s.tick = reg_wdata_i;
			end else if (reg_addr_i == ADDR_SCRATCH) begin
				next_s.scratch = reg_wdata_i;
			end else if (reg_addr_i == ADDR_RUN) begin
				next_s.run = reg_wdata_i;
			end else if (reg_addr_i == ADDR_DLY1) begin
				if (!running) begin
					next_s.dly1 = reg_wdata_i;
				end
			end else if (reg_addr_i == ADDR_DLY2) begin
				if (!running) begin
					next_s.dly2 = reg_wdata_i;
				end
			end else if (reg_addr_i == ADDR_MODE) begin
				if (!running) begin
					next_s.mode = reg_wdata_i;
				end
			end
		end
		if (reg_rd_i) begin
			next_s.rdata  = read_byte(reg_addr_i, s);
			next_s.rvalid = 1'b1;
		end
		for (int i = 0; i < CONV_CNT; i++) begin
			next_s.conv[i] = decode_rate(next_s.rate[RATE_W*i +: RATE_W]);
		end
		// Stopped but enabled monitor holds the drivers off
		next_s.drv_clr = !next_s.run[RUN_BIT] && next_s.mode[MON_EN_BIT];
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= PMC_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs and tick
	// ----------------------------------------------------------------
	assign reg_rdata_o               = s.rdata;
	assign reg_rvalid_o              = s.rvalid;
	assign conv1_rate_choice_o       = s.conv[0];
	assign conv2_rate_choice_o       = s.conv[1];
	assign conv3_rate_choice_o       = s.conv[2];
	assign conv4_rate_choice_o       = s.conv[3];
	assign sequencer_tick_exponent_o = s.tick[TICK_EXP_W-1:0];
	assign scratch_o                 = s.scratch[SCRATCH_W-1:0];
	assign monitor_run_bit_o         = s.run[RUN_BIT];
	assign monitor_enable_bit_o      = s.mode[MON_EN_BIT];
	assign monitor_mode_o            = s.mode[MODE_SEL_BIT];
	assign monitor_endrv_o           = s.mode[ENDRV_BIT];
	assign monitor_err_th_o          = s.mode[ERR_TH_W-1:0];
	assign monitor_first_delay_o     = s.dly1;
	assign monitor_second_delay_o    = s.dly2;
	assign driver_enable_clear_o     = s.drv_clr;

	pmc_tick_gen #(
		.BASE_NS   (TICK_BASE_NS),
		.PERIOD_NS (CLK_PERIOD_NS)
	) u_tick (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.tick_exp_i (s.tick[TICK_EXP_W-1:0]),
		.tick_o     (sequencer_tick_o)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_RATE_MAP: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(s.loaded && reg_wr_i && reg_addr_i == ADDR_RATE && s.rate_wr_en)
			|=> conv4_rate_choice_o == decode_rate($past(reg_wdata_i[7:6]))
			&& conv3_rate_choice_o == decode_rate($past(reg_wdata_i[5:4]))
			&& conv2_rate_choice_o == decode_rate($past(reg_wdata_i[3:2]))
			&& conv1_rate_choice_o == decode_rate($past(reg_wdata_i[1:0]))
	) else $error("rate select not mapped from written byte");

	AST_RATE_FAST: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		s.rate[1] |-> conv1_rate_choice_o == RATE_8M8
	) else $error("codes 10 and 11 must give the fastest rate");

	AST_RATE_LOCK: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(s.loaded && !s.rate_wr_en) |=> $stable(s.rate)
	) else $error("read-only rate register changed");

	AST_NVM_LOAD: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!s.loaded |=> s.loaded && s.rate == $past(nvm_rate_i)
			&& scratch_o == $past(nvm_scratch_i)
			&& sequencer_tick_exponent_o == $past(nvm_tick_exp_i)
			&& monitor_enable_bit_o == $past(nvm_mon_en_i)
	) else $error("non-volatile defaults not loaded");

	AST_DRV_CLEAR: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(s.loaded && reg_wr_i && reg_addr_i == ADDR_RUN
			&& !reg_wdata_i[RUN_BIT] && monitor_enable_bit_o)
			|=> driver_enable_clear_o ##1 (driver_enable_clear_o
			|| $past(reg_wr_i))
	) else $error("stopped enabled monitor must clear driver enable");

	AST_DLY1_WRITE: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(s.loaded && reg_wr_i && reg_addr_i == ADDR_DLY1 && !running)
			|=> monitor_first_delay_o == $past(reg_wdata_i)
	) else $error("first delay write while stopped lost");

	AST_DLY2_LOCK: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(reg_wr_i && reg_addr_i == ADDR_DLY2 && running)
			|=> $stable(monitor_second_delay_o)
	) else $error("second delay changed while monitor running");

	AST_EN_LOCK: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(s.loaded && running) |=> $stable(monitor_enable_bit_o)
	) else $error("monitor enable changed while running");

	AST_READ_BACK: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(reg_rd_i && reg_addr_i == ADDR_DLY1)
			|=> reg_rvalid_o && reg_rdata_o == $past(s.dly1)
	) else $error("read answer wrong or late");

endmodule

// ---- tb/pmc_host_model.sv ----
// Host-side register master standing in for the serial front end.
// Assumes the bank samples strobes on the rising edge of core_clk_i.
`timescale 1ns/1ps

module pmc_host_model (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i,
	output logic [7:0]      reg_addr_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic [7:0]      reg_wdata_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'h00;
	end

	// Strobe is a one-cycle pulse; data flips after so nothing stale shows
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge core_clk_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
			output logic ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		@(negedge core_clk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge core_clk_i);
		reg_rd_o = 1'b0;
		for (n = 0; n < 4; n++) begin
			if (reg_rvalid_i === 1'b1) begin
				d = reg_rdata_i;
				ok = 1'b1;
				break;
			end
			@(negedge core_clk_i);
		end
	endtask
endmodule

// ---- tb/pmc_cfg_bank_tb_top.sv ----
// Self-checking bench for the misc configuration bank.
// Assumes the host model is compiled before it.
`timescale 1ns/1ps

module pmc_cfg_bank_tb_top import pmc_pkg::*;;
	logic       core_clk_i = 1'b0;
	logic       sys_rst_i  = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, nvm_rate;
	logic       reg_wr, reg_rd, reg_rvalid, nvm_rate_wr_en, nvm_mon_en;
	logic [4:0] nvm_tick_exp, tick_exp;
	logic [3:0] nvm_scratch, scratch, err_th;
	logic       tick, run_bit, mon_en, mon_mode, mon_endrv, drv_clr;
	logic [7:0] dly1, dly2;
	pmc_rate_t  conv1, conv2, conv3, conv4;
	int         failures    = 0;
	int         comparisons = 0;
	int         n;

	always #4 core_clk_i = ~core_clk_i;

	pmc_host_model host_u (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata),
		.reg_rvalid_i(reg_rvalid), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));

	pmc_cfg_bank dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_wdata_i(reg_wdata), .nvm_rate_i(nvm_rate),
		.nvm_rate_wr_en_i(nvm_rate_wr_en), .nvm_tick_exp_i(nvm_tick_exp),
		.nvm_scratch_i(nvm_scratch), .nvm_mon_en_i(nvm_mon_en),
		.reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
		.conv1_rate_choice_o(conv1), .conv2_rate_choice_o(conv2),
		.conv3_rate_choice_o(conv3), .conv4_rate_choice_o(conv4),
		.sequencer_tick_exponent_o(tick_exp), .sequencer_tick_o(tick),
		.scratch_o(scratch), .monitor_run_bit_o(run_bit),
		.monitor_enable_bit_o(mon_en), .monitor_mode_o(mon_mode),
		.monitor_endrv_o(mon_endrv), .monitor_err_th_o(err_th),
		.monitor_first_delay_o(dly1), .monitor_second_delay_o(dly2),
		.driver_enable_clear_o(drv_clr));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host_u.rd(a, d, ok);
		if (ok !== 1'b1) begin
			failures++;
			tally_and_finish();
		end else begin
			chk(d, exp);
		end
	endtask

	task automatic chk_rates(input pmc_rate_t c4, c3, c2, c1);
		chk(8'(conv4), 8'(c4));
		chk(8'(conv3), 8'(c3));
		chk(8'(conv2), 8'(c2));
		chk(8'(conv1), 8'(c1));
	endtask

	task automatic do_reset(input logic wr_en, input logic [7:0] rate);
		@(negedge core_clk_i);
		sys_rst_i = 1'b1;
		nvm_rate_wr_en = wr_en;
		nvm_rate = rate;
		repeat (5) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
	endtask

	// Clocks spanning whole tick periods, timed from a tick on
	task automatic tick_span(input int periods, output int cnt);
		int seen;
		seen = 0;
		cnt = 0;
		while (seen <= periods && cnt < 4000) begin
			@(negedge core_clk_i);
			if (seen > 0) cnt++;
			if (tick === 1'b1) seen++;
		end
		if (seen <= periods) begin
			failures++;
			tally_and_finish();
		end
	endtask

	// Spans are chosen so the fractional jitter cancels out
	function automatic int span(input int e, input int periods);
		return TICK_BASE_NS * (2 ** e) * periods / CLK_PERIOD_NS;
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		nvm_tick_exp = 5'h03;
		nvm_scratch = 4'hA;
		nvm_mon_en = 1'b1;
		nvm_rate = 8'hE4;
		nvm_rate_wr_en = 1'b0;
		do_reset(1'b0, 8'hE4);
		chk_rates(RATE_8M8, RATE_8M8, RATE_4M4, RATE_2M2);
		rchk(ADDR_RATE, 8'hE4);
		rchk(ADDR_TICK, 8'h03);
		rchk(ADDR_SCRATCH, 8'h0A);
		rchk(ADDR_MODE, 8'h40);
		chk(8'({run_bit, drv_clr}), 8'h01);
		host_u.wr(ADDR_RATE, 8'h1B);
		rchk(ADDR_RATE, 8'hE4);
		$display("test defaults and locked rate done");

		tick_span(2, n);
		chk(8'(n), 8'(span(3, 2)));
		host_u.wr(ADDR_TICK, 8'hE1);
		chk(8'(tick_exp), 8'h01);
		rchk(ADDR_TICK, 8'hE1);
		tick_span(2, n);
		chk(8'(n), 8'(span(1, 2)));
		host_u.wr(ADDR_TICK, 8'h00);
		tick_span(4, n);
		chk(8'(n), 8'(span(0, 4)));
		$display("test tick scale done");

		// Delays set up before the monitor starts
		host_u.wr(ADDR_DLY1, 8'h55);
		host_u.wr(ADDR_DLY2, 8'hAA);
		host_u.wr(ADDR_MODE, 8'hC7);
		chk(dly1, 8'h55);
		chk(dly2, 8'hAA);
		chk({mon_mode, mon_en, mon_endrv, 1'b0, err_th}, 8'hC7);
		host_u.wr(ADDR_RUN, 8'h01);
		chk(8'({run_bit, drv_clr}), 8'h02);
		host_u.wr(ADDR_DLY1, 8'h12);
		host_u.wr(ADDR_DLY2, 8'h34);
		host_u.wr(ADDR_MODE, 8'h00);
		rchk(ADDR_DLY1, 8'h55);
		rchk(ADDR_DLY2, 8'hAA);
		rchk(ADDR_MODE, 8'hC7);
		host_u.wr(ADDR_RUN, 8'h00);
		chk(8'({run_bit, drv_clr}), 8'h01);
		host_u.wr(ADDR_MODE, 8'h00);
		chk(8'({mon_en, drv_clr}), 8'h00);
		$display("test monitor lock done");

		do_reset(1'b1, 8'h00);
		host_u.wr(ADDR_RATE, 8'h9C);
		chk_rates(RATE_8M8, RATE_4M4, RATE_8M8, RATE_2M2);
		rchk(ADDR_RATE, 8'h9C);
		host_u.wr(ADDR_SCRATCH, 8'hF5);
		chk(8'(scratch), 8'h05);
		rchk(ADDR_SCRATCH, 8'hF5);
		rchk(8'h8C, 8'h00);
		$display("test writable rate done");
		tally_and_finish();
	end
endmodule
